// File: rtl/tlia_axil.sv
// AXI4-Lite slave front end of the interrupt aggregator
// assumes the register decode answers rd_data/rd_ok/wr_ok combinationally
`default_nettype none

module tlia_axil (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [tlia_pkg::TLIA_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read
  input wire logic [tlia_pkg::TLIA_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wr_en,
  output logic [tlia_pkg::TLIA_AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [tlia_pkg::TLIA_AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  import tlia_pkg::*;

  logic aw_have_q;
  logic w_have_q;

  // ==========================================================
  // write channel: address and data taken in either order
  assign awready = !aw_have_q && !bvalid;
  assign wready = !w_have_q && !bvalid;
  assign wr_en = aw_have_q && w_have_q && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      aw_have_q <= 1'b1;
      wr_addr <= awaddr;
    end else if (wr_en) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wvalid && wready) begin
      w_have_q <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (wr_en) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= TLIA_RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? TLIA_RESP_OKAY : TLIA_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // read channel: data captured at the address handshake
  assign arready = !rvalid;
  assign rd_en = arvalid && arready;
  assign rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= TLIA_RESP_OKAY;
    end else if (rd_en) begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_ok ? TLIA_RESP_OKAY : TLIA_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: rtl/tlia_pkg.sv
// shared constants of the two-level interrupt aggregator
// assumes a single 10 MHz clock and a 32-bit AXI4-Lite register port
`default_nettype none

package tlia_pkg;

  // ==========================================================
  // bus geometry and responses
  localparam int unsigned TLIA_AW = 8;
  localparam int unsigned TLIA_DW = 32;
  localparam logic [1:0] TLIA_RESP_OKAY = 2'h0;
  localparam logic [1:0] TLIA_RESP_SLVERR = 2'h2;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] TLIA_OFF_NORMAL = 8'h00;
  localparam logic [7:0] TLIA_OFF_FAST = 8'h04;
  localparam logic [7:0] TLIA_OFF_MASK = 8'h08;
  localparam logic [7:0] TLIA_OFF_LEVEL = 8'h0c;
  localparam logic [7:0] TLIA_OFF_ACTIVE = 8'h10;
  localparam logic [7:0] TLIA_OFF_CTRL = 8'h14;
  localparam logic [7:0] TLIA_OFF_EVT_STAT = 8'h18;
  localparam logic [7:0] TLIA_OFF_EVT_CLR = 8'h1c;
  localparam logic [7:0] TLIA_OFF_EVT_EN = 8'h20;

  // ==========================================================
  // values after reset
  localparam logic [31:0] TLIA_MASK_RST = 32'h0;
  localparam logic [31:0] TLIA_LEVEL_RST = 32'h0;
  localparam logic [1:0] TLIA_CTRL_RST = 2'h0;
  localparam logic [2:0] TLIA_EVT_RST = 3'h0;

  // ==========================================================
  // field positions
  localparam int unsigned TLIA_CTRL_NORMAL_EN = 0;
  localparam int unsigned TLIA_CTRL_FAST_EN = 1;
  localparam int unsigned TLIA_EVT_NORMAL = 0;
  localparam int unsigned TLIA_EVT_FAST = 1;
  localparam int unsigned TLIA_EVT_BUSERR = 2;

  localparam int unsigned TLIA_BIT_RTC_ALARM = 31;
  localparam int unsigned TLIA_BIT_RTC_TICK = 30;
  localparam int unsigned TLIA_BIT_OST_LO = 26;
  localparam int unsigned TLIA_BIT_DMA_LO = 20;
  localparam int unsigned TLIA_BIT_SSP = 19;
  localparam int unsigned TLIA_BIT_CODEC = 18;
  localparam int unsigned TLIA_BIT_UART3 = 17;
  localparam int unsigned TLIA_BIT_HSSER = 16;
  localparam int unsigned TLIA_BIT_UART1 = 15;
  localparam int unsigned TLIA_BIT_SDLC = 14;
  localparam int unsigned TLIA_BIT_USB = 13;
  localparam int unsigned TLIA_BIT_LCD = 12;
  localparam int unsigned TLIA_BIT_GPIO_OR = 11;

  // ==========================================================
  // second-level source counts
  localparam int unsigned TLIA_OST_N = 4;
  localparam int unsigned TLIA_DMA_N = 6;
  localparam int unsigned TLIA_DMA_SUB = 3;
  localparam int unsigned TLIA_SSP_N = 3;
  localparam int unsigned TLIA_CODEC_N = 8;
  localparam int unsigned TLIA_UART_N = 6;
  localparam int unsigned TLIA_HSSER_N = 12;
  localparam int unsigned TLIA_SDLC_N = 5;
  localparam int unsigned TLIA_USB_N = 6;
  localparam int unsigned TLIA_LCD_N = 12;
  localparam int unsigned TLIA_GPIO_N = 28;

  // byte-lane merge of a write
  function automatic logic [31:0] tlia_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

`default_nettype wire

// File: rtl/tlia_top.sv
// first-level interrupt aggregator: pending views, mask, routing, core outputs
// assumes all source status bits are on aclk; the core samples the two outputs
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none

// Notes on behaviour
// [R1] Software sees a normal pending view, a fast pending view, a mask and a routing level.
// [R2] After reset both core interrupt outputs stay off; register contents are not relied on.
// [R3] Software programs every register before enabling interrupts in the core.
// [R4] The 32-bit active source view is read only and writes to it do nothing.
// [R5] Active source bits show their source whatever the mask holds.
// [R6] Bit 31 is the clock alarm match and bit 30 the one-hertz tick.
// [R7] Bits 26 to 29 are the timer matches 0 to 3, one source each.
// [R8] Bits 20 to 25 are DMA channels 0 to 5, each the OR of three sources.
// [R9] Bits 13 to 19 are the serial units and bit 12 the display, OR of twelve sources.
// [R10] Bits 0 to 10 follow the same-numbered pin edge and bit 11 ORs pins 11 to 27.
// [R11] A handler finds a merged unit from the pending view, then reads that unit.
// [R12] A single-source bit names its cause from these registers alone.
// [R13] Each routing bit sends an active unmasked source to the normal or fast view.
// [R14] Outside idle mode a source reaches the core only while its mask bit is one.
// [R15] In idle mode the mask is ignored and any request wakes the processor.
// [R16] A pending bit is the OR of its unit's status bits and drops when they clear.
// [R17] Routing zero means normal and one means fast; each output ORs its routed bits.

module tlia_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [tlia_pkg::TLIA_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [tlia_pkg::TLIA_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // second-level status from the source units
  input wire logic rtc_alarm,
  input wire logic rtc_tick,
  input wire logic [tlia_pkg::TLIA_OST_N-1:0] ost_match,
  input wire logic [tlia_pkg::TLIA_DMA_N*tlia_pkg::TLIA_DMA_SUB-1:0] dma_status,
  input wire logic [tlia_pkg::TLIA_SSP_N-1:0] sync_serial_port_status,
  input wire logic [tlia_pkg::TLIA_CODEC_N-1:0] codec_serial_port_status,
  input wire logic [tlia_pkg::TLIA_UART_N-1:0] uart3_status,
  input wire logic [tlia_pkg::TLIA_HSSER_N-1:0] high_speed_serial_status,
  input wire logic [tlia_pkg::TLIA_UART_N-1:0] uart1_status,
  input wire logic [tlia_pkg::TLIA_SDLC_N-1:0] sdlc_status,
  input wire logic [tlia_pkg::TLIA_USB_N-1:0] usb_device_port_status,
  input wire logic [tlia_pkg::TLIA_LCD_N-1:0] lcd_status,
  input wire logic [tlia_pkg::TLIA_GPIO_N-1:0] gpio_edge,
  // power state
  input wire logic idle_mode,
  // processor core side
  output logic normal_interrupt_request,
  output logic fast_interrupt_request,
  output logic wake_request,
  // housekeeping interrupt
  output logic sys_irq
);
  import tlia_pkg::*;

  // ==========================================================
  // declarations
  logic [31:0] active_w;
  logic [31:0] eff_mask_w;
  logic [31:0] normal_irq_pending;
  logic [31:0] fast_irq_pending;
  logic [31:0] source_mask_q;
  logic [31:0] routing_level_q;
  logic [1:0] ctrl_q;
  logic [2:0] evt_stat_q;
  logic [2:0] evt_en_q;
  logic [2:0] evt_hit_w;
  logic normal_any_w;
  logic fast_any_w;
  logic normal_prev_q;
  logic fast_prev_q;
  logic wr_en;
  logic [TLIA_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [TLIA_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  // ==========================================================
  // gathering of second-level status into first-level bits
  assign active_w[TLIA_BIT_RTC_ALARM] = rtc_alarm; // see [R6]
  assign active_w[TLIA_BIT_RTC_TICK] = rtc_tick; // see [R6]
  assign active_w[TLIA_BIT_OST_LO +: TLIA_OST_N] = ost_match; // see [R7]
  assign active_w[TLIA_BIT_SSP] = |sync_serial_port_status; // see [R9]
  assign active_w[TLIA_BIT_CODEC] = |codec_serial_port_status; // see [R9]
  assign active_w[TLIA_BIT_UART3] = |uart3_status; // see [R9]
  assign active_w[TLIA_BIT_HSSER] = |high_speed_serial_status; // see [R9]
  assign active_w[TLIA_BIT_UART1] = |uart1_status; // see [R9]
  assign active_w[TLIA_BIT_SDLC] = |sdlc_status; // see [R9]
  assign active_w[TLIA_BIT_USB] = |usb_device_port_status; // see [R9]
  assign active_w[TLIA_BIT_LCD] = |lcd_status; // see [R9] see [R16]
  assign active_w[TLIA_BIT_GPIO_OR] = |gpio_edge[TLIA_GPIO_N-1:TLIA_BIT_GPIO_OR]; // see [R10]

  // combinational OR, so a bit drops as soon as the unit clears its status
  for (genvar ch = 0; ch < TLIA_DMA_N; ch++) begin : g_dma
    assign active_w[TLIA_BIT_DMA_LO+ch] = |dma_status[ch*TLIA_DMA_SUB +: TLIA_DMA_SUB]; // see [R8] see [R16]
  end

  for (genvar p = 0; p < TLIA_BIT_GPIO_OR; p++) begin : g_gpio
    assign active_w[p] = gpio_edge[p]; // see [R10]
  end

  // ==========================================================
  // masking and routing
  assign eff_mask_w = idle_mode ? '1 : source_mask_q; // see [R15] see [R14]
  assign normal_irq_pending = active_w & eff_mask_w & ~routing_level_q; // see [R13] see [R17]
  assign fast_irq_pending = active_w & eff_mask_w & routing_level_q; // see [R13] see [R17]
  assign normal_any_w = |normal_irq_pending; // see [R17]
  assign fast_any_w = |fast_irq_pending; // see [R17]

  // ==========================================================
  // software-written registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_mask_q <= TLIA_MASK_RST;
    end else if (wr_en && wr_addr == TLIA_OFF_MASK) begin
      source_mask_q <= tlia_merge(source_mask_q, wr_data, wr_strb); // see [R1]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      routing_level_q <= TLIA_LEVEL_RST;
    end else if (wr_en && wr_addr == TLIA_OFF_LEVEL) begin
      routing_level_q <= tlia_merge(routing_level_q, wr_data, wr_strb); // see [R1]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= TLIA_CTRL_RST; // see [R2]
    end else if (wr_en && wr_addr == TLIA_OFF_CTRL && wr_strb[0]) begin
      ctrl_q <= wr_data[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_en_q <= TLIA_EVT_RST;
    end else if (wr_en && wr_addr == TLIA_OFF_EVT_EN && wr_strb[0]) begin
      evt_en_q <= wr_data[2:0];
    end
  end

  // ==========================================================
  // core outputs, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      normal_interrupt_request <= 1'b0; // see [R2]
      fast_interrupt_request <= 1'b0; // see [R2]
      wake_request <= 1'b0;
    end else begin
      normal_interrupt_request <= normal_any_w && ctrl_q[TLIA_CTRL_NORMAL_EN]; // see [R14]
      fast_interrupt_request <= fast_any_w && ctrl_q[TLIA_CTRL_FAST_EN]; // see [R14]
      wake_request <= idle_mode && (|active_w); // see [R15]
    end
  end

  // ==========================================================
  // housekeeping events: sticky, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      normal_prev_q <= 1'b0;
      fast_prev_q <= 1'b0;
    end else begin
      normal_prev_q <= normal_any_w;
      fast_prev_q <= fast_any_w;
    end
  end

  assign evt_hit_w[TLIA_EVT_NORMAL] = normal_any_w && !normal_prev_q;
  assign evt_hit_w[TLIA_EVT_FAST] = fast_any_w && !fast_prev_q;
  assign evt_hit_w[TLIA_EVT_BUSERR] = (wr_en && !wr_ok) || (rd_en && !rd_ok);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_stat_q <= TLIA_EVT_RST;
    end else if (wr_en && wr_addr == TLIA_OFF_EVT_CLR && wr_strb[0]) begin
      evt_stat_q <= (evt_stat_q & ~wr_data[2:0]) | evt_hit_w;
    end else begin
      evt_stat_q <= evt_stat_q | evt_hit_w;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_irq <= 1'b0;
    end else begin
      sys_irq <= |(evt_stat_q & evt_en_q);
    end
  end

  // ==========================================================
  // register decode
  always_comb begin
    rd_ok = 1'b1;
    rd_data = '0;
    if (rd_addr == TLIA_OFF_NORMAL) begin
      rd_data = normal_irq_pending;
    end else if (rd_addr == TLIA_OFF_FAST) begin
      rd_data = fast_irq_pending;
    end else if (rd_addr == TLIA_OFF_MASK) begin
      rd_data = source_mask_q;
    end else if (rd_addr == TLIA_OFF_LEVEL) begin
      rd_data = routing_level_q;
    end else if (rd_addr == TLIA_OFF_ACTIVE) begin
      rd_data = active_w; // see [R4] see [R5]
    end else if (rd_addr == TLIA_OFF_CTRL) begin
      rd_data = {30'h0, ctrl_q};
    end else if (rd_addr == TLIA_OFF_EVT_STAT) begin
      rd_data = {29'h0, evt_stat_q};
    end else if (rd_addr == TLIA_OFF_EVT_CLR) begin
      rd_data = '0;
    end else if (rd_addr == TLIA_OFF_EVT_EN) begin
      rd_data = {29'h0, evt_en_q};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read-only offsets accept a write with OKAY and change nothing
  always_comb begin
    wr_ok = 1'b1;
    if (wr_addr == TLIA_OFF_NORMAL || wr_addr == TLIA_OFF_FAST) begin
      wr_ok = 1'b1;
    end else if (wr_addr == TLIA_OFF_ACTIVE || wr_addr == TLIA_OFF_EVT_STAT) begin
      wr_ok = 1'b1; // see [R4]
    end else if (wr_addr == TLIA_OFF_MASK || wr_addr == TLIA_OFF_LEVEL) begin
      wr_ok = 1'b1;
    end else if (wr_addr == TLIA_OFF_CTRL || wr_addr == TLIA_OFF_EVT_CLR) begin
      wr_ok = 1'b1;
    end else if (wr_addr == TLIA_OFF_EVT_EN) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // ==========================================================
  // bus front end
  tlia_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence normal_rise_s;
    normal_any_w && !normal_prev_q;
  endsequence

  // held for a second cycle unless software cleared it in between
  sequence evt_seen_s;
    evt_stat_q[TLIA_EVT_NORMAL] ##1
      (evt_stat_q[TLIA_EVT_NORMAL] || $past(wr_en && wr_addr == TLIA_OFF_EVT_CLR));
  endsequence

  reset_quiet_a: assert property (disable iff (1'b0) // see [R2]
    !aresetn |=> !normal_interrupt_request && !fast_interrupt_request && ctrl_q == 2'h0)
    else $error("core outputs not off after reset");

  rtc_bits_a: assert property ( // see [R6]
    active_w[31] == rtc_alarm && active_w[30] == rtc_tick)
    else $error("clock bits misplaced");

  ost_bits_a: assert property ( // see [R7]
    active_w[29:26] == ost_match)
    else $error("timer match bits misplaced");

  dma_or_a: assert property ( // see [R8]
    active_w[25] == |dma_status[17:15] && active_w[20] == |dma_status[2:0])
    else $error("dma channel merge wrong");

  lcd_or_a: assert property ( // see [R9]
    active_w[12] == |lcd_status && active_w[19] == |sync_serial_port_status)
    else $error("serial or display merge wrong");

  gpio_map_a: assert property ( // see [R10]
    active_w[10:0] == gpio_edge[10:0] && active_w[11] == |gpio_edge[27:11])
    else $error("pin edge bits wrong");

  route_split_a: assert property ( // see [R13]
    (normal_irq_pending & fast_irq_pending) == 32'h0 &&
    (normal_irq_pending | fast_irq_pending) == (active_w & eff_mask_w))
    else $error("routing split wrong");

  mask_gate_a: assert property ( // see [R14]
    !idle_mode |-> ((normal_irq_pending | fast_irq_pending) & ~source_mask_q) == 32'h0)
    else $error("masked source reached a view");

  fast_out_a: assert property ( // see [R17]
    (|(active_w & source_mask_q & routing_level_q)) && ctrl_q[1] && !idle_mode
    |=> fast_interrupt_request)
    else $error("fast output missed a routed source");

  idle_wake_a: assert property ( // see [R15]
    idle_mode && (|(active_w & ~routing_level_q)) && ctrl_q[0]
    |=> wake_request && normal_interrupt_request)
    else $error("idle request did not wake");

  ro_write_a: assert property ( // see [R4]
    wr_en && wr_addr == TLIA_OFF_ACTIVE
    |=> $stable(source_mask_q) && $stable(routing_level_q) && $stable(ctrl_q))
    else $error("read-only write changed state");

  evt_sticky_a: assert property (
    normal_rise_s and !(wr_en && wr_addr == TLIA_OFF_EVT_CLR) |=> evt_seen_s)
    else $error("normal event not held");

endmodule

`default_nettype wire

// File: sim/tlia_src_model.sv
// source unit model: sticky second-level status bits, cleared by writing one
// assumes the bench pulses set and clear strobes on aclk
`default_nettype none

module tlia_src_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // strobes from the bench
  input wire logic [109:0] set_v,
  input wire logic [109:0] clr_v,
  // status levels to the aggregator
  output logic [109:0] stat
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // status bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~clr_v) | set_v;
    end
  end
endmodule

`default_nettype wire

// File: sim/tlia_top_tb.sv
// bench of the interrupt aggregator: bus tasks, source stimulus, register checks
// assumes the package offsets and one source model on all status inputs
`default_nettype none

module tlia_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tlia_pkg::*;
  // ==========================================================
  // signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic idle_mode = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [109:0] set_v = '0;
  logic [109:0] clr_v = '0;
  logic [109:0] stat;
  logic awready, wready, bvalid, arready, rvalid, nirq, firq, wake, sys_irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  int n_errors = 0;
  int compares = 0;

  always #50 aclk = ~aclk;

  tlia_src_model i_tlia_src_model (.aclk(aclk), .aresetn(aresetn), .set_v(set_v),
    .clr_v(clr_v), .stat(stat));

  tlia_top i_tlia_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rtc_alarm(stat[0]), .rtc_tick(stat[1]), .ost_match(stat[5:2]),
    .dma_status(stat[23:6]), .sync_serial_port_status(stat[26:24]),
    .codec_serial_port_status(stat[34:27]), .uart3_status(stat[40:35]),
    .high_speed_serial_status(stat[52:41]), .uart1_status(stat[58:53]),
    .sdlc_status(stat[63:59]), .usb_device_port_status(stat[69:64]),
    .lcd_status(stat[81:70]), .gpio_edge(stat[109:82]), .idle_mode(idle_mode),
    .normal_interrupt_request(nirq), .fast_interrupt_request(firq),
    .wake_request(wake), .sys_irq(sys_irq));

  // ==========================================================
  // compares and bus tasks
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk_w(rd, exp);
  endtask

  task automatic src(input logic [109:0] s, input logic [109:0] c);
    @(posedge aclk);
    set_v <= s;
    clr_v <= c;
    @(posedge aclk);
    set_v <= '0;
    clr_v <= '0;
  endtask

  function automatic logic [31:0] exp_view(input logic [109:0] s);
    logic [31:0] v;
    v[31] = s[0];
    v[30] = s[1];
    v[29:26] = s[5:2];
    for (int c = 0; c < 6; c++) begin
      v[20+c] = |s[6+3*c +: 3];
    end
    v[19] = |s[26:24];
    v[18] = |s[34:27];
    v[17] = |s[40:35];
    v[16] = |s[52:41];
    v[15] = |s[58:53];
    v[14] = |s[63:59];
    v[13] = |s[69:64];
    v[12] = |s[81:70];
    v[11] = |s[109:93];
    v[10:0] = s[92:82];
    return v;
  endfunction

  task automatic end_of_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    logic [109:0] one;
    one = 110'h1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk_b(nirq, 1'b0);
    chk_b(firq, 1'b0);
    rdchk(TLIA_OFF_MASK, TLIA_MASK_RST);
    rdchk(TLIA_OFF_LEVEL, TLIA_LEVEL_RST);
    rdchk(TLIA_OFF_CTRL, {30'h0, TLIA_CTRL_RST});
    rdchk(8'h24, 32'h0);
    chk_w({30'h0, rs}, {30'h0, TLIA_RESP_SLVERR});
    $display("test reset done");
    for (int i = 0; i < 110; i++) begin
      src(one << i, '0);
      rdchk(TLIA_OFF_ACTIVE, exp_view(one << i));
      src('0, one << i);
      rdchk(TLIA_OFF_ACTIVE, 32'h0);
    end
    src(110'h0c0, '0);
    src('0, 110'h040);
    rdchk(TLIA_OFF_ACTIVE, 32'h0010_0000);
    chk_w({29'h0, stat[8:6]}, 32'h2);
    src('0, 110'h080);
    axw(TLIA_OFF_ACTIVE, 32'hffff_ffff);
    chk_w({30'h0, rs}, {30'h0, TLIA_RESP_OKAY});
    rdchk(TLIA_OFF_ACTIVE, 32'h0);
    $display("test sources done");
    src({110{1'b1}}, '0);
    axw(TLIA_OFF_MASK, 32'h00ff_ff00);
    axw(TLIA_OFF_LEVEL, 32'h0f0f_0f0f);
    axw(TLIA_OFF_CTRL, 32'h3);
    rdchk(TLIA_OFF_NORMAL, 32'h00f0_f000);
    rdchk(TLIA_OFF_FAST, 32'h000f_0f00);
    chk_b(nirq, 1'b1);
    chk_b(firq, 1'b1);
    axw(TLIA_OFF_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk_b(nirq, 1'b0);
    chk_b(firq, 1'b0);
    rdchk(TLIA_OFF_ACTIVE, 32'hffff_ffff);
    rdchk(TLIA_OFF_NORMAL, 32'h0);
    $display("test routing done");
    idle_mode <= 1'b1;
    rdchk(TLIA_OFF_NORMAL, 32'hf0f0_f0f0);
    chk_b(wake, 1'b1);
    chk_b(nirq, 1'b1);
    idle_mode <= 1'b0;
    $display("test idle done");
    axw(TLIA_OFF_CTRL, 32'h0);
    rdchk(TLIA_OFF_EVT_STAT, 32'h7);
    chk_b(sys_irq, 1'b0);
    axw(TLIA_OFF_EVT_EN, 32'h7);
    repeat (2) @(posedge aclk);
    chk_b(sys_irq, 1'b1);
    axw(TLIA_OFF_EVT_CLR, 32'h7);
    rdchk(TLIA_OFF_EVT_STAT, 32'h0);
    chk_b(sys_irq, 1'b0);
    $display("test events done");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    end_of_test();
  end
endmodule

`default_nettype wire
